//--- rtl/ecapt_pkg.sv
package ecapt_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) /
                                        CLK_PERIOD_NS;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  // free-running count
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
  localparam logic [6:0] P128_LAST = 7'h7f;
  localparam logic [9:0] P1024_LAST = 10'h3ff;

  // bus
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [7:0] IDX_TMR_LO = 8'h24;
  localparam logic [7:0] IDX_TMR_HI = 8'h25;
  localparam logic [7:0] IDX_CAP_A_RISE = 8'h40;
  localparam logic [7:0] IDX_CAP_A_FALL = 8'h41;
  localparam logic [7:0] IDX_CAP_B_RISE = 8'h42;
  localparam logic [7:0] IDX_CAP_B_FALL = 8'h43;
  localparam logic [7:0] IDX_SETUP = 8'h44;
  localparam logic [7:0] IDX_FLAGS = 8'h45;
  localparam logic [7:0] IDX_GIE = 8'h46;

  // capture_setup fields and the global enable bit
  localparam int SETUP_HOLD_BIT = 7;
  localparam int SETUP_PS_MSB = 6;
  localparam int SETUP_PS_LSB = 4;
  localparam int SETUP_EN_MSB = 3;
  localparam int GIE_CAP_BIT = 0;

  // event order in flags, enables and data registers
  localparam int EV_A_RISE = 0;
  localparam int EV_A_FALL = 1;
  localparam int EV_B_RISE = 2;
  localparam int EV_B_FALL = 3;
  localparam int NUM_EV = 4;

  // reset values
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [3:0] NIB_RESET = 4'h0;

  typedef enum logic [4:0]
  {
    ECAPT_PS_1US = 5'h01,
    ECAPT_PS_2US = 5'h02,
    ECAPT_PS_4US = 5'h04,
    ECAPT_PS_8US = 5'h08,
    ECAPT_PS_16US = 5'h10
  } ecapt_step_t;

endpackage

//--- rtl/ecapt_tmr_if.sv
`timescale 1ns/1ns
interface ecapt_tmr_if;
  logic [11:0] count;
  logic tick;
  logic irq_128us;
  logic irq_1024us;

  modport tmr
  (
    output count,
    output tick,
    output irq_128us,
    output irq_1024us
  );

  modport usr
  (
    input count,
    input tick,
    input irq_128us,
    input irq_1024us
  );
endinterface

//--- rtl/ecapt_timer.sv
`timescale 1ns/1ns
module ecapt_timer
(
  input wire logic clock,
  input wire logic rst,
  ecapt_tmr_if.tmr tif
);

  logic [ecapt_pkg::DIV_W-1:0] div_q;
  logic [ecapt_pkg::CNT_W-1:0] cnt_q;
  logic p128_q;
  logic p1024_q;
  logic tick;
  logic [ecapt_pkg::DIV_W-1:0] gap_q;
  logic seen_q;

  assign tick = (div_q == ecapt_pkg::DIV_LAST);
  assign tif.count = cnt_q;
  assign tif.tick = tick;
  assign tif.irq_128us = p128_q;
  assign tif.irq_1024us = p1024_q;

  // microsecond divider
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      div_q <= '0;
    else if (tick)
      div_q <= '0;
    else
      div_q <= div_q + 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_q <= ecapt_pkg::CNT_RESET;
    else if (tick)
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      p128_q <= 1'b0;
      p1024_q <= 1'b0;
    end
    else
    begin
      p128_q <= tick && (cnt_q[6:0] == ecapt_pkg::P128_LAST);
      p1024_q <= tick && (cnt_q[9:0] == ecapt_pkg::P1024_LAST);
    end
  end

  // helper: cycles since the previous tick
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      gap_q <= '0;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q <= tick ? '0 : gap_q + 1'b1;
      seen_q <= seen_q | tick;
    end
  end

  property p_tick_period;
    @(posedge clock) disable iff (rst)
      (tick && seen_q) |-> (gap_q == ecapt_pkg::DIV_LAST);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick spacing wrong");

  property p_count_step;
    @(posedge clock) disable iff (rst)
      tick |=> (cnt_q == 12'($past(cnt_q) + 12'h001));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step on tick");

  property p_wrap;
    @(posedge clock) disable iff (rst)
      (tick && cnt_q == ecapt_pkg::CNT_MAX) |=> (cnt_q == 12'h000);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not wrap to zero");

  property p_irq_period;
    @(posedge clock) disable iff (rst)
      p1024_q |-> (cnt_q[9:0] == 10'h000) && p128_q;
  endproperty
  a_irq_period: assert property (p_irq_period)
    else $error("periodic request at wrong count");

endmodule

//--- rtl/ecapt_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// - 12-bit count advances every microsecond
// - requests every 128 us and 1.024 ms
// - low byte read latches upper bits
// - high byte returns latched upper bits
// - high byte upper nibble reads zero
// - channel A pin 0, B pin 1
// - edges store count slice in data registers
// - prescale field picks the stored slice
// - codes 0-4 select bits 7:0 to 11:4
// - capture data registers are read-only
// - status bits 3..0 are B fall..A rise
// - reading data register clears its flag
// - setup: hold 7, prescale 6:4, enables 3:0
// - each event has its own enable
// - interrupt needs event and global enable
// - hold mode keeps first edge until read
// - default mode keeps latest edge
// - hold mode applies to all four registers
module ecapt_top
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cap_a_pin,
  input wire logic cap_b_pin,
  output logic irq_cap_a,
  output logic irq_cap_b,
  output logic irq_128us,
  output logic irq_1024us
);

  localparam int NE = ecapt_pkg::NUM_EV;

  ecapt_tmr_if tif ();

  ecapt_timer u_timer
  (
    .clock(clock),
    .rst(rst),
    .tif(tif)
  );

  // word index of a byte address, 8'hff when unmapped or misaligned
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[1:0] != 2'b00 || a[11:10] != 2'b00)
      reg_index = 8'hff;
    else if (idx == ecapt_pkg::IDX_TMR_LO || idx == ecapt_pkg::IDX_TMR_HI)
      reg_index = idx;
    else if (idx >= ecapt_pkg::IDX_CAP_A_RISE && idx <= ecapt_pkg::IDX_GIE)
      reg_index = idx;
    else
      reg_index = 8'hff;
  endfunction

  // eight-bit slice of the count chosen by prescale
  function automatic logic [7:0] count_slice(input logic [11:0] c,
                                             input logic [2:0] ps);
    case (ps)
      3'h0: count_slice = c[7:0];
      3'h1: count_slice = c[8:1];
      3'h2: count_slice = c[9:2];
      3'h3: count_slice = c[10:3];
      default: count_slice = c[11:4];
    endcase
  endfunction

  // ---------------- pin synchronisers and edge detect
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [NE-1:0] ev;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
      pin_s3_q <= 2'b00;
    end
    else
    begin
      pin_s1_q <= {cap_b_pin, cap_a_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign ev[ecapt_pkg::EV_A_RISE] = pin_s2_q[0] & ~pin_s3_q[0];
  assign ev[ecapt_pkg::EV_A_FALL] = ~pin_s2_q[0] & pin_s3_q[0];
  assign ev[ecapt_pkg::EV_B_RISE] = pin_s2_q[1] & ~pin_s3_q[1];
  assign ev[ecapt_pkg::EV_B_FALL] = ~pin_s2_q[1] & pin_s3_q[1];

  // ---------------- bus decode
  logic [7:0] idx;
  logic setup_ph;
  logic rd_done;
  logic wr_done;

  assign idx = reg_index(paddr);
  assign setup_ph = psel && !penable;
  assign rd_done = psel && penable && pready && !pwrite;
  assign wr_done = psel && penable && pready && pwrite;

  // ---------------- configuration registers
  logic [7:0] setup_q;
  logic gie_q;
  logic hold_mode;
  logic [2:0] prescale;
  logic [NE-1:0] ev_en;

  assign hold_mode = setup_q[ecapt_pkg::SETUP_HOLD_BIT];
  assign prescale = setup_q[ecapt_pkg::SETUP_PS_MSB:ecapt_pkg::SETUP_PS_LSB];
  assign ev_en = setup_q[ecapt_pkg::SETUP_EN_MSB:0];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      setup_q <= ecapt_pkg::REG8_RESET;
    else if (wr_done && idx == ecapt_pkg::IDX_SETUP)
      setup_q <= pwdata[7:0];
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gie_q <= 1'b0;
    else if (wr_done && idx == ecapt_pkg::IDX_GIE)
      gie_q <= pwdata[ecapt_pkg::GIE_CAP_BIT];
  end

  // ---------------- coherent timer read
  logic [11:0] snap_q;
  logic [3:0] upper_q;

  // the count seen at setup is the one returned, so latch from the same copy
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      snap_q <= ecapt_pkg::CNT_RESET;
    else if (setup_ph)
      snap_q <= tif.count;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      upper_q <= ecapt_pkg::NIB_RESET;
    else if (rd_done && idx == ecapt_pkg::IDX_TMR_LO)
      upper_q <= snap_q[11:8];
  end

  // ---------------- capture registers and flags
  logic [7:0] cap_q [NE];
  logic [NE-1:0] flag_q;
  logic [NE-1:0] rd_clr;
  logic [7:0] slice;

  assign slice = count_slice(tif.count, prescale);

  // clear at the edge that samples the read data, so an edge there survives
  always_comb
  begin
    rd_clr = '0;
    for (int i = 0; i < NE; i++)
      if (setup_ph && !pwrite && idx == ecapt_pkg::IDX_CAP_A_RISE + 8'(i))
        rd_clr[i] = 1'b1;
  end

  // writes never reach cap_q: only edges load it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NE; i++)
        cap_q[i] <= ecapt_pkg::REG8_RESET;
    end
    else
    begin
      for (int i = 0; i < NE; i++)
        if (ev[i] && (!hold_mode || !flag_q[i] || rd_clr[i]))
          cap_q[i] <= slice;
    end
  end

  // a new edge wins over the clear by read
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_q <= '0;
    else
    begin
      for (int i = 0; i < NE; i++)
        if (ev[i])
          flag_q[i] <= 1'b1;
        else if (rd_clr[i])
          flag_q[i] <= 1'b0;
    end
  end

  // ---------------- read data and handshake
  logic [31:0] rdata_d;
  logic err_d;

  always_comb
  begin
    rdata_d = '0;
    err_d = 1'b0;
    case (idx)
      ecapt_pkg::IDX_TMR_LO: rdata_d[7:0] = tif.count[7:0];
      ecapt_pkg::IDX_TMR_HI: rdata_d[3:0] = upper_q;
      ecapt_pkg::IDX_CAP_A_RISE: rdata_d[7:0] = cap_q[ecapt_pkg::EV_A_RISE];
      ecapt_pkg::IDX_CAP_A_FALL: rdata_d[7:0] = cap_q[ecapt_pkg::EV_A_FALL];
      ecapt_pkg::IDX_CAP_B_RISE: rdata_d[7:0] = cap_q[ecapt_pkg::EV_B_RISE];
      ecapt_pkg::IDX_CAP_B_FALL: rdata_d[7:0] = cap_q[ecapt_pkg::EV_B_FALL];
      ecapt_pkg::IDX_SETUP: rdata_d[7:0] = setup_q;
      ecapt_pkg::IDX_FLAGS: rdata_d[3:0] = flag_q;
      ecapt_pkg::IDX_GIE: rdata_d[ecapt_pkg::GIE_CAP_BIT] = gie_q;
      default: err_d = 1'b1;
    endcase
  end

  // one wait-free access: ready in the access cycle, dropped after
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph && err_d;
      if (setup_ph)
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
    end
  end

  // ---------------- interrupt outputs
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq_cap_a <= 1'b0;
      irq_cap_b <= 1'b0;
      irq_128us <= 1'b0;
      irq_1024us <= 1'b0;
    end
    else
    begin
      irq_cap_a <= gie_q && |(flag_q[1:0] & ev_en[1:0]);
      irq_cap_b <= gie_q && |(flag_q[3:2] & ev_en[3:2]);
      irq_128us <= tif.irq_128us;
      irq_1024us <= tif.irq_1024us;
    end
  end

  // ---------------- checks
  property p_latch;
    @(posedge clock) disable iff (rst)
      (rd_done && idx == ecapt_pkg::IDX_TMR_LO) |=>
        (upper_q == $past(snap_q[11:8]));
  endproperty
  a_latch: assert property (p_latch)
    else $error("upper bits not latched on low read");

  property p_high_read;
    @(posedge clock) disable iff (rst)
      (setup_ph && !pwrite && idx == ecapt_pkg::IDX_TMR_HI) |=>
        (prdata == {28'h0, $past(upper_q)}) && pready;
  endproperty
  a_high_read: assert property (p_high_read)
    else $error("high byte did not return latched bits");

  property p_read_only;
    @(posedge clock) disable iff (rst)
      !$stable(cap_q[ecapt_pkg::EV_A_RISE]) |-> $past(ev[ecapt_pkg::EV_A_RISE]);
  endproperty
  a_read_only: assert property (p_read_only)
    else $error("capture register changed without an edge");

  property p_flag_clear;
    @(posedge clock) disable iff (rst)
      (rd_clr[ecapt_pkg::EV_B_FALL] && !ev[ecapt_pkg::EV_B_FALL]) |=>
        !flag_q[ecapt_pkg::EV_B_FALL];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by data read");

  property p_first_edge;
    @(posedge clock) disable iff (rst)
      (hold_mode && flag_q[ecapt_pkg::EV_B_RISE] &&
       !rd_clr[ecapt_pkg::EV_B_RISE]) |=>
        $stable(cap_q[ecapt_pkg::EV_B_RISE]);
  endproperty
  a_first_edge: assert property (p_first_edge)
    else $error("held capture was overwritten");

  property p_last_edge;
    @(posedge clock) disable iff (rst)
      (!hold_mode && ev[ecapt_pkg::EV_B_RISE]) |=>
        (cap_q[ecapt_pkg::EV_B_RISE] == $past(slice)) &&
        flag_q[ecapt_pkg::EV_B_RISE];
  endproperty
  a_last_edge: assert property (p_last_edge)
    else $error("latest edge not captured");

  property p_irq_gate;
    @(posedge clock) disable iff (rst)
      irq_cap_a |-> $past(gie_q) &&
        $past(|(flag_q[1:0] & ev_en[1:0]));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("capture interrupt without enables");

  property p_edge_once;
    @(posedge clock) disable iff (rst)
      ev[ecapt_pkg::EV_A_RISE] |=> !ev[ecapt_pkg::EV_A_RISE] ##1
        !ev[ecapt_pkg::EV_A_RISE] || pin_s3_q[0];
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("edge seen twice");

  property p_slice_max;
    @(posedge clock) disable iff (rst)
      (prescale == 3'h4 && ev[ecapt_pkg::EV_B_FALL] && !hold_mode) |=>
        (cap_q[ecapt_pkg::EV_B_FALL] == $past(tif.count[11:4]));
  endproperty
  a_slice_max: assert property (p_slice_max)
    else $error("wrong prescale slice");

endmodule

//--- bench/test_edge_capture_timer.sv
`timescale 1ns/1ns
module test_edge_capture_timer;
  logic clock;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cap_a_pin;
  logic cap_b_pin;
  logic irq_cap_a;
  logic irq_cap_b;
  logic irq_128us;
  logic irq_1024us;
  wire logic [1:0] irqs = {irq_cap_b, irq_cap_a};
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n128 = 0;
  int n1024 = 0;
  int last128 = 0;
  logic [31:0] d;
  logic er;
  logic [11:0] e;
  logic [11:0] e1;
  logic [11:0] e2;
  int ev;

  ecapt_top i_dut
  (
    .clock(clock),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cap_a_pin(cap_a_pin),
    .cap_b_pin(cap_b_pin),
    .irq_cap_a(irq_cap_a),
    .irq_cap_b(irq_cap_b),
    .irq_128us(irq_128us),
    .irq_1024us(irq_1024us)
  );

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask

  // waits for the 128 us pulse; count is then a multiple of 128
  task automatic wait_128(output logic [11:0] ex);
    do
      @(posedge clock);
    while (irq_128us !== 1'b1);
    ex = 12'((n128 + 1) * 128);
  endtask

  // toggles the pin of an event right after a 128 us pulse
  task automatic edge_ev(input int evn, output logic [11:0] ex);
    wait_128(ex);
    if (evn < 2)
      cap_a_pin <= ~cap_a_pin;
    else
      cap_b_pin <= ~cap_b_pin;
    repeat (8) @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc >= 90000)
    begin
      fail_count++;
      results();
    end
    if (irq_128us === 1'b1)
    begin
      if (n128 != 0)
        check(32'(cyc - last128), 32'(ecapt_pkg::TICK_CYCLES * 128));
      last128 <= cyc;
      n128 <= n128 + 1;
    end
    if (irq_1024us === 1'b1)
    begin
      check({31'h0, irq_128us}, 32'h1);
      n1024 <= n1024 + 1;
    end
  end

  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cap_a_pin = 1'b0;
    cap_b_pin = 1'b0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    // reset values of every register except the timer low byte
    for (int i = 0; i < 7; i++)
    begin
      rd(8'(ecapt_pkg::IDX_CAP_A_RISE + i));
      check(d, 32'h0);
    end
    rd(ecapt_pkg::IDX_TMR_HI);
    check(d, 32'h0);
    rd(ecapt_pkg::IDX_GIE);
    check(d, 32'h0);
    rd(8'h30);
    check({d[30:0], er}, 32'h1);
    wr(ecapt_pkg::IDX_SETUP, 32'ha5);
    rd(ecapt_pkg::IDX_SETUP);
    check(d, 32'ha5);
    // coherent timer read
    wait_128(e);
    rd(ecapt_pkg::IDX_TMR_LO);
    check(d, {24'h0, e[7:0]});
    rd(ecapt_pkg::IDX_TMR_HI);
    check(d, {28'h0, e[11:8]});
    wait_128(e1);
    wait_128(e1);
    rd(ecapt_pkg::IDX_TMR_HI);
    check(d, {28'h0, e[11:8]});
    // prescale codes 0 to 4, every event
    wr(ecapt_pkg::IDX_GIE, 32'h0);
    for (int ps = 0; ps < 5; ps++)
    begin
      ev = ps % 4;
      wr(ecapt_pkg::IDX_SETUP, {25'h0, 3'(ps), 4'hf ^ (4'h1 << ev)});
      edge_ev(ev, e);
      rd(ecapt_pkg::IDX_FLAGS);
      check(d, 32'h1 << ev);
      check({31'h0, irqs[ev / 2]}, 32'h0);
      wr(ecapt_pkg::IDX_SETUP, {25'h0, 3'(ps), 4'hf});
      repeat (2) @(posedge clock);
      if (ps == 0)
      begin
        check({31'h0, irqs[0]}, 32'h0);
        wr(ecapt_pkg::IDX_GIE, 32'h1);
        repeat (2) @(posedge clock);
      end
      check({31'h0, irqs[ev / 2]}, 32'h1);
      wr(8'(ecapt_pkg::IDX_CAP_A_RISE + ev), 32'hff);
      rd(8'(ecapt_pkg::IDX_CAP_A_RISE + ev));
      check(d, {24'h0, 8'(e >> ps)});
      rd(ecapt_pkg::IDX_FLAGS);
      check(d, 32'h0);
    end
    // first edge kept while held
    wr(ecapt_pkg::IDX_SETUP, 32'h80);
    edge_ev(2, e1);
    edge_ev(3, e2);
    edge_ev(2, e);
    rd(ecapt_pkg::IDX_CAP_B_RISE);
    check(d, {24'h0, e1[7:0]});
    rd(ecapt_pkg::IDX_CAP_B_FALL);
    check(d, {24'h0, e2[7:0]});
    // latest edge kept by default, coarsest prescale
    wr(ecapt_pkg::IDX_SETUP, 32'h40);
    edge_ev(3, e1);
    edge_ev(2, e2);
    edge_ev(3, e);
    rd(ecapt_pkg::IDX_CAP_B_FALL);
    check(d, {24'h0, 8'(e >> 4)});
    rd(ecapt_pkg::IDX_CAP_B_RISE);
    check(d, {24'h0, 8'(e2 >> 4)});
    // count wraps to zero and keeps running
    do
      wait_128(e);
    while (e != 12'h000);
    rd(ecapt_pkg::IDX_TMR_LO);
    check(d, 32'h0);
    rd(ecapt_pkg::IDX_TMR_HI);
    check(d, 32'h0);
    wait_128(e1);
    rd(ecapt_pkg::IDX_TMR_LO);
    check(d, {24'h0, e1[7:0]});
    check(32'(n1024), 32'(n128 / 8));
    results();
  end
endmodule
